// file: page_ctrl_if.sv
// Page pointers and mode bits shared between page modules
`include "sram_page_defines.svh"
`default_nettype none
interface page_ctrl_if;
    logic [1:0] mode;
    logic [`PAGE_W-1:0] cur;
    logic [`PAGE_W-1:0] stk;
    logic [`PAGE_W-1:0] idx;
    logic [`PAGE_W-1:0] brd;
    logic [`PAGE_W-1:0] bwr;
    modport ctrl (output mode, cur, stk, idx, brd, bwr);
    modport sel (input mode, cur, stk, idx, brd, bwr);
endinterface
`default_nettype wire

// file: page_flags.sv
// Flag register with interrupt clear and return restore
`include "sram_page_defines.svh"
`default_nettype none
module page_flags (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Software write
    input wire logic sw_we,
    input wire logic [`REG_DW-1:0] sw_wdata,
    // Interrupt entry and return
    input wire logic irq_entry,
    input wire logic return_from_isr,
    input wire logic [`REG_DW-1:0] return_flags,
    // Flag value
    output logic [`REG_DW-1:0] flags
);
    logic [`REG_DW-1:0] next_flags;

    // Entry beats return, return beats software
    always_comb begin
        next_flags = flags;
        if (irq_entry) begin
            next_flags = `FLAGS_RST;
        end else if (return_from_isr) begin
            next_flags = return_flags;
        end else if (sw_we) begin
            next_flags = sw_wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flags <= `FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    property p_entry_clears;
        @(posedge mclk) disable iff (!resetn)
        irq_entry |=> flags == `FLAGS_RST;
    endproperty
    a_entry_clears: assert property (p_entry_clears)
        else $error("flags not cleared on interrupt entry");

    property p_return_restores;
        @(posedge mclk) disable iff (!resetn)
        return_from_isr && !irq_entry |=> flags == $past(return_flags);
    endproperty
    a_return_restores: assert property (p_return_restores)
        else $error("flags not restored on return");
endmodule
`default_nettype wire

// file: page_mux.sv
// Page source selection for one SRAM access
`include "sram_page_defines.svh"
`default_nettype none
module page_mux (
    // Pointer and mode state
    page_ctrl_if.sel pc,
    // Access in flight
    input wire sram_page_pkg::access_class_type acc_class,
    input wire logic [`OFF_W-1:0] acc_offset,
    // Physical address
    output logic [`PHYS_W-1:0] phys_addr
);
    function automatic logic [`PAGE_W-1:0] page_of(
        input sram_page_pkg::access_class_type cls,
        input logic [1:0] mode,
        input logic [`PAGE_W-1:0] cur,
        input logic [`PAGE_W-1:0] stk,
        input logic [`PAGE_W-1:0] idx,
        input logic [`PAGE_W-1:0] brd,
        input logic [`PAGE_W-1:0] bwr
    );
        logic [`PAGE_W-1:0] pg;
        pg = `PAGE_RST;
        case (cls)
            sram_page_pkg::ACC_STACK: begin
                pg = stk;
            end
            sram_page_pkg::ACC_MOVE_READ: begin
                pg = brd;
            end
            sram_page_pkg::ACC_MOVE_WRITE: begin
                pg = bwr;
            end
            sram_page_pkg::ACC_INDEXED: begin
                case (mode)
                    `MODE_FORCE0: pg = `PAGE_RST;
                    `MODE_INDEX: pg = idx;
                    default: pg = stk;
                endcase
            end
            default: begin
                pg = mode[1] ? cur : `PAGE_RST;
            end
        endcase
        return pg;
    endfunction

    always_comb begin
        phys_addr = {page_of(acc_class, pc.mode, pc.cur, pc.stk,
            pc.idx, pc.brd, pc.bwr), acc_offset};
    end
endmodule
`default_nettype wire

// file: sram_page_defines.svh
// Constants for the SRAM page extension logic
`ifndef SRAM_PAGE_DEFINES_SVH
`define SRAM_PAGE_DEFINES_SVH

// Widths
`define PAGE_W 3
`define OFF_W 8
`define PHYS_W 11
`define REG_AW 8
`define REG_DW 8

// Register offsets
`define CURRENT_PAGE_OFF 8'hD0
`define STACK_PAGE_OFF 8'hD1
`define INDEX_PAGE_OFF 8'hD3
`define BLOCK_READ_PAGE_OFF 8'hD4
`define BLOCK_WRITE_PAGE_OFF 8'hD5
`define LAST_PAGE_OFF 8'hF6
`define FLAGS_OFF 8'hF7

// Flag fields
`define MODE_HI 7
`define MODE_LO 6

// Reset values
`define FLAGS_RST 8'h00
`define PAGE_RST 3'h0
`define DATA_ZERO 8'h00

// Page select modes for indexed accesses
`define MODE_FORCE0 2'h0
`define MODE_INDEX 2'h2

`endif

// file: sram_page_mem_model.sv
// Paged SRAM array that takes the block's physical accesses
`include "sram_page_defines.svh"
`default_nettype none
module sram_page_mem_model (
    // Clock
    input wire logic mclk,
    // Access from the block
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [`PHYS_W-1:0] mem_addr,
    input wire logic [`REG_DW-1:0] mem_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Eight pages of 256 bytes
    logic [7:0] mem [0:2047];
    // Page bits above the offset pick the row
    always @(posedge mclk) begin
        if (mem_req === 1'b1 && mem_we === 1'b1) begin
            mem[mem_addr] = mem_wdata;
        end
    end
endmodule
`default_nettype wire

// file: sram_page_pkg.sv
// Types for the SRAM page extension logic
`default_nettype none
package sram_page_pkg;
    typedef enum logic [2:0] {
        ACC_NORMAL,
        ACC_STACK,
        ACC_MOVE_PTR,
        ACC_MOVE_READ,
        ACC_MOVE_WRITE,
        ACC_INDEXED
    } access_class_type;
endpackage
`default_nettype wire

// file: sram_page_select.sv
// Top of the SRAM page extension logic for an 8-bit CPU
`include "sram_page_defines.svh"
`default_nettype none
module sram_page_select #(
    parameter int PAGE_W = `PAGE_W,
    parameter int OFF_W = `OFF_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [`REG_AW-1:0] reg_addr,
    input wire logic [`REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`REG_DW-1:0] reg_rdata,
    // CPU access request
    input wire logic cpu_req,
    input wire sram_page_pkg::access_class_type cpu_class,
    input wire logic [OFF_W-1:0] cpu_offset,
    input wire logic cpu_we,
    input wire logic [`REG_DW-1:0] cpu_wdata,
    // Interrupt entry and return
    input wire logic irq_entry,
    input wire logic [OFF_W-1:0] irq_stack_ptr,
    input wire logic return_from_isr,
    input wire logic [`REG_DW-1:0] return_flags,
    // Flag view
    output logic [`REG_DW-1:0] flags_out,
    // SRAM side
    output logic mem_req,
    output logic mem_we,
    output logic [PAGE_W+OFF_W-1:0] mem_addr,
    output logic [`REG_DW-1:0] mem_wdata
);
    page_ctrl_if pc ();

    logic [PAGE_W-1:0] current_page_ptr;
    logic [PAGE_W-1:0] stack_page_ptr;
    logic [PAGE_W-1:0] index_page_ptr;
    logic [PAGE_W-1:0] block_read_page_ptr;
    logic [PAGE_W-1:0] block_write_page_ptr;
    logic [PAGE_W-1:0] last_page;
    logic [PAGE_W-1:0] next_current_page_ptr;
    logic [PAGE_W-1:0] next_stack_page_ptr;
    logic [PAGE_W-1:0] next_index_page_ptr;
    logic [PAGE_W-1:0] next_block_read_page_ptr;
    logic [PAGE_W-1:0] next_block_write_page_ptr;
    logic [PAGE_W-1:0] next_last_page;
    logic [`REG_DW-1:0] next_reg_rdata;
    logic next_mem_req;
    logic next_mem_we;
    logic [PAGE_W+OFF_W-1:0] next_mem_addr;
    logic [`REG_DW-1:0] next_mem_wdata;
    logic [PAGE_W+OFF_W-1:0] phys_addr;
    logic [1:0] page_select_bits;
    logic flags_we;

    function automatic logic [`REG_DW-1:0] page_word(
        input logic [PAGE_W-1:0] pg
    );
        return {{(`REG_DW-PAGE_W){1'b0}}, pg};
    endfunction

    // Shared pointer and mode view
    assign page_select_bits = flags_out[`MODE_HI:`MODE_LO];
    assign pc.mode = page_select_bits;
    assign pc.cur = current_page_ptr;
    assign pc.stk = stack_page_ptr;
    assign pc.idx = index_page_ptr;
    assign pc.brd = block_read_page_ptr;
    assign pc.bwr = block_write_page_ptr;
    assign flags_we = reg_wr && (reg_addr == `FLAGS_OFF);

    page_flags u_flags (
        .mclk(mclk),
        .resetn(resetn),
        .sw_we(flags_we),
        .sw_wdata(reg_wdata),
        .irq_entry(irq_entry),
        .return_from_isr(return_from_isr),
        .return_flags(return_flags),
        .flags(flags_out)
    );

    page_mux u_mux (
        .pc(pc),
        .acc_class(cpu_class),
        .acc_offset(cpu_offset),
        .phys_addr(phys_addr)
    );

    // Pointer register writes, low bits kept
    always_comb begin
        next_current_page_ptr = current_page_ptr;
        next_stack_page_ptr = stack_page_ptr;
        next_index_page_ptr = index_page_ptr;
        next_block_read_page_ptr = block_read_page_ptr;
        next_block_write_page_ptr = block_write_page_ptr;
        if (reg_wr) begin
            case (reg_addr)
                `CURRENT_PAGE_OFF: begin
                    next_current_page_ptr = reg_wdata[PAGE_W-1:0];
                end
                `STACK_PAGE_OFF: begin
                    next_stack_page_ptr = reg_wdata[PAGE_W-1:0];
                end
                `INDEX_PAGE_OFF: begin
                    next_index_page_ptr = reg_wdata[PAGE_W-1:0];
                end
                `BLOCK_READ_PAGE_OFF: begin
                    next_block_read_page_ptr = reg_wdata[PAGE_W-1:0];
                end
                `BLOCK_WRITE_PAGE_OFF: begin
                    next_block_write_page_ptr = reg_wdata[PAGE_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data for one cycle after the strobe
    always_comb begin
        next_reg_rdata = `DATA_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                `CURRENT_PAGE_OFF: begin
                    next_reg_rdata = page_word(current_page_ptr);
                end
                `STACK_PAGE_OFF: next_reg_rdata = page_word(stack_page_ptr);
                `INDEX_PAGE_OFF: next_reg_rdata = page_word(index_page_ptr);
                `BLOCK_READ_PAGE_OFF: begin
                    next_reg_rdata = page_word(block_read_page_ptr);
                end
                `BLOCK_WRITE_PAGE_OFF: begin
                    next_reg_rdata = page_word(block_write_page_ptr);
                end
                `LAST_PAGE_OFF: next_reg_rdata = page_word(last_page);
                `FLAGS_OFF: next_reg_rdata = flags_out;
                default: next_reg_rdata = `DATA_ZERO;
            endcase
        end
    end

    // SRAM access issue, interrupt push first
    always_comb begin
        next_mem_req = 1'b0;
        next_mem_we = 1'b0;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        if (irq_entry) begin
            next_mem_req = 1'b1;
            next_mem_we = 1'b1;
            next_mem_addr = {stack_page_ptr, irq_stack_ptr};
            next_mem_wdata = flags_out;
        end else if (cpu_req) begin
            next_mem_req = 1'b1;
            next_mem_we = cpu_we;
            next_mem_addr = phys_addr;
            next_mem_wdata = cpu_wdata;
        end
        next_last_page = next_mem_req ?
            next_mem_addr[PAGE_W+OFF_W-1:OFF_W] : last_page;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            current_page_ptr <= `PAGE_RST;
            stack_page_ptr <= `PAGE_RST;
            index_page_ptr <= `PAGE_RST;
            block_read_page_ptr <= `PAGE_RST;
            block_write_page_ptr <= `PAGE_RST;
            last_page <= `PAGE_RST;
            reg_rdata <= `DATA_ZERO;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= {(PAGE_W+OFF_W){1'b0}};
            mem_wdata <= `DATA_ZERO;
        end else begin
            current_page_ptr <= next_current_page_ptr;
            stack_page_ptr <= next_stack_page_ptr;
            index_page_ptr <= next_index_page_ptr;
            block_read_page_ptr <= next_block_read_page_ptr;
            block_write_page_ptr <= next_block_write_page_ptr;
            last_page <= next_last_page;
            reg_rdata <= next_reg_rdata;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
        end
    end

    // Checks
    sequence s_cpu(sram_page_pkg::access_class_type c);
        cpu_req && !irq_entry && cpu_class == c;
    endsequence

    property p_reset_zero;
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |-> flags_out == `FLAGS_RST &&
            current_page_ptr == `PAGE_RST && stack_page_ptr == `PAGE_RST &&
            index_page_ptr == `PAGE_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("paging state not zero after reset");

    property p_normal_page0;
        @(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_NORMAL) and !flags_out[`MODE_HI] |=>
            mem_req && mem_addr[PAGE_W+OFF_W-1:OFF_W] == `PAGE_RST;
    endproperty
    a_normal_page0: assert property (p_normal_page0)
        else $error("normal access left page 0 with paging off");

    property p_normal_current;
        @(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_NORMAL) and flags_out[`MODE_HI] |=>
            mem_addr[PAGE_W+OFF_W-1:OFF_W] == $past(current_page_ptr);
    endproperty
    a_normal_current: assert property (p_normal_current)
        else $error("normal access missed current page");

    property p_stack_page;
        @(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_STACK) |=>
            mem_addr == {$past(stack_page_ptr), $past(cpu_offset)};
    endproperty
    a_stack_page: assert property (p_stack_page)
        else $error("stack access not on stack page");

    property p_irq_push;
        @(posedge mclk) disable iff (!resetn)
        irq_entry |=> mem_req && mem_we &&
            mem_wdata == $past(flags_out) &&
            mem_addr == {$past(stack_page_ptr), $past(irq_stack_ptr)} &&
            flags_out == `FLAGS_RST;
    endproperty
    a_irq_push: assert property (p_irq_push)
        else $error("interrupt entry push or clear wrong");

    property p_move_ptr;
        @(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_MOVE_PTR) |=>
            mem_addr[PAGE_W+OFF_W-1:OFF_W] ==
            ($past(flags_out[`MODE_HI]) ? $past(current_page_ptr)
                                        : `PAGE_RST);
    endproperty
    a_move_ptr: assert property (p_move_ptr)
        else $error("move pointer access off current page");

    property p_move_read;
        @(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_MOVE_READ) |=>
            mem_addr[PAGE_W+OFF_W-1:OFF_W] == $past(block_read_page_ptr);
    endproperty
    a_move_read: assert property (p_move_read)
        else $error("move read not on read page");

    property p_move_write;
        @(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_MOVE_WRITE) |=>
            mem_addr[PAGE_W+OFF_W-1:OFF_W] == $past(block_write_page_ptr);
    endproperty
    a_move_write: assert property (p_move_write)
        else $error("move write not on write page");

    property p_indexed;
        @(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_INDEXED) |=>
            mem_addr[PAGE_W+OFF_W-1:OFF_W] ==
            ($past(page_select_bits) == `MODE_FORCE0 ? `PAGE_RST :
             $past(page_select_bits) == `MODE_INDEX ?
             $past(index_page_ptr) : $past(stack_page_ptr));
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed access on wrong page");

    property p_idle;
        @(posedge mclk) disable iff (!resetn)
        !cpu_req && !irq_entry |=> !mem_req;
    endproperty
    a_idle: assert property (p_idle)
        else $error("SRAM access without a request");

    c_irq_then_return: cover property (@(posedge mclk)
        disable iff (!resetn) irq_entry ##[1:20] return_from_isr);
    c_index_mode: cover property (@(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_INDEXED) and
        page_select_bits == `MODE_INDEX);
    c_move_write: cover property (@(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_MOVE_WRITE));
    c_paged_normal: cover property (@(posedge mclk) disable iff (!resetn)
        s_cpu(sram_page_pkg::ACC_NORMAL) and flags_out[`MODE_HI]);
endmodule
`default_nettype wire

// file: sram_page_select_tb.sv
// Self-checking bench for the SRAM page extension logic
`include "sram_page_defines.svh"
`default_nettype none
module sram_page_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic cpu_req = 1'b0;
    sram_page_pkg::access_class_type cpu_class = sram_page_pkg::ACC_NORMAL;
    logic [7:0] cpu_offset = 8'h00;
    logic cpu_we = 1'b0;
    logic [7:0] cpu_wdata = 8'h00;
    logic irq_entry = 1'b0;
    logic [7:0] irq_stack_ptr = 8'h00;
    logic return_from_isr = 1'b0;
    logic [7:0] return_flags = 8'h00;
    logic [7:0] flags_out;
    logic mem_req;
    logic mem_we;
    logic [10:0] mem_addr;
    logic [7:0] mem_wdata;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    sram_page_select u_dut (.mclk(mclk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_req(cpu_req),
        .cpu_class(cpu_class), .cpu_offset(cpu_offset), .cpu_we(cpu_we),
        .cpu_wdata(cpu_wdata), .irq_entry(irq_entry),
        .irq_stack_ptr(irq_stack_ptr), .return_from_isr(return_from_isr),
        .return_flags(return_flags), .flags_out(flags_out),
        .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    sram_page_mem_model u_sram (.mclk(mclk), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    always #50 mclk = ~mclk;
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_addr(string what, logic [10:0] exp, logic [10:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_check(logic [7:0] a, logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk_byte("reg_rdata", exp, reg_rdata);
    endtask
    // One access, then the physical address one cycle later
    task automatic access(sram_page_pkg::access_class_type c,
                          logic [7:0] off, logic [2:0] pg);
        @(posedge mclk);
        cpu_req <= 1'b1;
        cpu_class <= c;
        cpu_offset <= off;
        cpu_we <= off[0];
        cpu_wdata <= off ^ 8'h5A;
        @(posedge mclk);
        cpu_req <= 1'b0;
        #1;
        chk_byte("mem_req", 8'h01, {7'h00, mem_req});
        chk_byte("mem_we", {7'h00, off[0]}, {7'h00, mem_we});
        chk_byte("mem_wdata", off ^ 8'h5A, mem_wdata);
        chk_addr("mem_addr", {pg, off}, mem_addr);
    endtask
    // Expected page for a class under a page mode
    function automatic logic [2:0] exp_page(
        sram_page_pkg::access_class_type c, logic [1:0] m);
        case (c)
            sram_page_pkg::ACC_STACK: return 3'h2;
            sram_page_pkg::ACC_MOVE_READ: return 3'h6;
            sram_page_pkg::ACC_MOVE_WRITE: return 3'h7;
            sram_page_pkg::ACC_INDEXED: begin
                if (m == 2'h0) return 3'h0;
                if (m == 2'h2) return 3'h3;
                return 3'h2;
            end
            default: return m[1] ? 3'h5 : 3'h0;
        endcase
    endfunction
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        // Reset state
        chk_byte("flags_out", 8'h00, flags_out);
        reg_check(`CURRENT_PAGE_OFF, 8'h00);
        reg_check(`STACK_PAGE_OFF, 8'h00);
        reg_check(`INDEX_PAGE_OFF, 8'h00);
        reg_check(`BLOCK_READ_PAGE_OFF, 8'h00);
        reg_check(`BLOCK_WRITE_PAGE_OFF, 8'h00);
        access(sram_page_pkg::ACC_NORMAL, 8'h10, 3'h0);
        $display("test reset done");
        // Pointer setup, width of page fields
        reg_write(`CURRENT_PAGE_OFF, 8'hFD);
        reg_check(`CURRENT_PAGE_OFF, 8'h05);
        reg_write(`STACK_PAGE_OFF, 8'h02);
        reg_write(`INDEX_PAGE_OFF, 8'h03);
        reg_write(`BLOCK_READ_PAGE_OFF, 8'h06);
        reg_write(`BLOCK_WRITE_PAGE_OFF, 8'h07);
        reg_write(8'h42, 8'hAA);
        reg_check(8'h42, 8'h00);
        $display("test pointers done");
        // Every class under every page mode
        for (int m = 0; m < 4; m++) begin
            reg_write(`FLAGS_OFF, {m[1:0], 6'h00});
            for (int k = 0; k < 6; k++) begin
                access(sram_page_pkg::access_class_type'(k), 8'h33,
                       exp_page(sram_page_pkg::access_class_type'(k),
                                m[1:0]));
            end
        end
        reg_check(`LAST_PAGE_OFF, 8'h02);
        $display("test modes done");
        // Stack wrap stays on the stack page, then move pointer and move read pages
        access(sram_page_pkg::ACC_STACK, 8'hFF, 3'h2);
        access(sram_page_pkg::ACC_STACK, 8'h00, 3'h2);
        access(sram_page_pkg::ACC_MOVE_PTR, 8'h20, 3'h5);
        access(sram_page_pkg::ACC_MOVE_READ, 8'h21, 3'h6);
        $display("test stack done");
        // Interrupt entry and return
        @(posedge mclk);
        irq_entry <= 1'b1;
        irq_stack_ptr <= 8'h80;
        @(posedge mclk);
        irq_entry <= 1'b0;
        #1;
        chk_byte("push mem_req", 8'h01, {7'h00, mem_req});
        chk_byte("push mem_we", 8'h01, {7'h00, mem_we});
        chk_addr("push mem_addr", 11'h280, mem_addr);
        chk_byte("push mem_wdata", 8'hC0, mem_wdata);
        chk_byte("flags_out", 8'h00, flags_out);
        @(posedge mclk);
        #1;
        chk_byte("mem_req", 8'h00, {7'h00, mem_req});
        chk_byte("sram push", 8'hC0, u_sram.mem[11'h280]);
        access(sram_page_pkg::ACC_NORMAL, 8'h44, 3'h0);
        reg_write(`FLAGS_OFF, 8'h40);
        access(sram_page_pkg::ACC_INDEXED, 8'h45, 3'h2);
        reg_write(`INDEX_PAGE_OFF, 8'h04);
        reg_write(`FLAGS_OFF, 8'h80);
        access(sram_page_pkg::ACC_INDEXED, 8'h48, 3'h4);
        reg_write(`INDEX_PAGE_OFF, 8'h03);
        reg_check(`INDEX_PAGE_OFF, 8'h03);
        @(posedge mclk);
        return_from_isr <= 1'b1;
        return_flags <= 8'hC0;
        @(posedge mclk);
        return_from_isr <= 1'b0;
        #1;
        chk_byte("flags_out", 8'hC0, flags_out);
        access(sram_page_pkg::ACC_NORMAL, 8'h46, 3'h5);
        access(sram_page_pkg::ACC_INDEXED, 8'h47, 3'h2);
        $display("test interrupt done");
        end_of_test();
    end
endmodule
`default_nettype wire
